//--- hw/cca_cfg.svh
// Constants of the counter array: register indices, field positions, reset values.
// Assumes inclusion by cca_pkg and the design modules by bare name.
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// Register indices on the special-function port
`define CCA_A_CTRL 8'h00
`define CCA_A_AMODE 8'h01
`define CCA_A_CNTL 8'h02
`define CCA_A_CNTH 8'h03
`define CCA_A_PWMCFG 8'h04
`define CCA_A_PINLVL 8'h05
`define CCA_A_MODE 8'h08
`define CCA_A_CMPL 8'h10
`define CCA_A_CMPH 8'h18
`define CCA_NCH 6
`define CCA_NCH8 8'h06

// Channel mode register fields
`define CCA_M_PWM16 7
`define CCA_M_CMPEN 6
`define CCA_M_RISE 5
`define CCA_M_FALL 4
`define CCA_M_MATCH 3
`define CCA_M_TOG 2
`define CCA_M_PWM 1
`define CCA_M_IRQEN 0

// Array control register fields
`define CCA_C_CF 7
`define CCA_C_RUN 6

// PWM cycle configuration fields
`define CCA_P_VIEW 7
`define CCA_P_CYCLE_OVERFLOW_FLAG 6
`define CCA_P_COVEN 5
`define CCA_P_CLS_HI 1

// Array mode register field
`define CCA_AM_CFEN 0

// Values
`define CCA_ZERO8 8'h00
`define CCA_ZERO16 16'h0000
`define CCA_ONES16 16'hFFFF
`define CCA_ONE16 16'h0001
`define CCA_CYC_BASE 17'h0_0100
`define CCA_CFG_RMASK 8'hE3

`endif

//--- hw/cca_chan.sv
// One capture/compare channel: pin synchroniser, edge capture, compare and pin output.
// Assumes the core holds compare data and applies captures and frequency steps.
`timescale 1ns/1ps
`include "cca_cfg.svh"

module cca_chan (
    input wire logic i_clk,      // System clock
    input wire logic i_rst_n,    // Synchronised reset, active low
    cca_chan_if.chan ch          // Link to the core
);
    cca_pkg::cca_chan_st_t st_reg, st_next;
    cca_pkg::cca_mode_t md;
    logic [15:0] mask;
    logic rise, fall, en, mat, m16, mn, mlo;

    // Decode, edge detect and pin output; s1 feeds only s2 to keep metastability out
    always_comb begin
        st_next = st_reg;
        st_next.s1 = ch.pin_raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        md = cca_pkg::cca_decode(ch.mode);
        mask = cca_pkg::cca_cyc_mask(ch.cls);
        rise = st_reg.s2 & ~st_reg.s3;
        fall = ~st_reg.s2 & st_reg.s3;
        en = ch.mode[`CCA_M_CMPEN];
        mat = ch.mode[`CCA_M_MATCH];
        m16 = ch.step && (ch.cnt == ch.cmp);
        mn = ch.step && ((ch.cnt & mask) == (ch.cmp & mask));
        mlo = ch.step && (ch.cnt[7:0] == ch.cmp[7:0]);
        ch.cap = 1'b0;
        ch.evt = 1'b0;
        ch.fstep = 1'b0;
        case (md)
            cca_pkg::CCA_CAPTURE: begin
                ch.cap = (rise & ch.mode[`CCA_M_RISE]) | (fall & ch.mode[`CCA_M_FALL]);
                ch.evt = ch.cap;
            end
            cca_pkg::CCA_SWTIMER: begin
                ch.evt = en & mat & m16;
            end
            cca_pkg::CCA_HSO: begin
                ch.evt = en & mat & m16;
                if (en && m16) begin
                    st_next.out = ~st_reg.out;
                end
            end
            cca_pkg::CCA_FREQ: begin
                ch.evt = en & mat & m16;
                if (en && mlo) begin
                    st_next.out = ~st_reg.out;
                    ch.fstep = 1'b1;
                end
            end
            cca_pkg::CCA_PWM_SHORT: begin
                ch.evt = en & mat & mn;
                // Match wins over overflow so a zero compare gives a full duty cycle
                if (!en) begin
                    st_next.out = 1'b0;
                end else if (mn) begin
                    st_next.out = 1'b1;
                end else if (ch.cov) begin
                    st_next.out = 1'b0;
                end
            end
            cca_pkg::CCA_PWM16: begin
                ch.evt = en & mat & m16;
                if (!en) begin
                    st_next.out = 1'b0;
                end else if (m16) begin
                    st_next.out = 1'b1;
                end else if (ch.ovf16) begin
                    st_next.out = 1'b0;
                end
            end
            default: begin
                ch.evt = 1'b0;
            end
        endcase
        ch.pin_out = st_reg.out;
        ch.pin_lvl = st_reg.s2;
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

//--- hw/cca_chan_if.sv
// Carrier between the array core and one channel slice.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface cca_chan_if;
    logic [7:0] mode;
    logic [15:0] cmp;
    logic [15:0] cnt;
    logic [1:0] cls;
    logic step;
    logic ovf16;
    logic cov;
    logic pin_raw;
    logic cap;
    logic evt;
    logic fstep;
    logic pin_out;
    logic pin_lvl;

    modport top(output mode, cmp, cnt, cls, step, ovf16, cov, pin_raw,
                input cap, evt, fstep, pin_out, pin_lvl);
    modport chan(input mode, cmp, cnt, cls, step, ovf16, cov, pin_raw,
                 output cap, evt, fstep, pin_out, pin_lvl);
endinterface

//--- hw/cca_pkg.sv
// Types and decode helpers shared by the counter array and its channels.
// Assumes cca_cfg.svh is on the include path.
`include "cca_cfg.svh"

package cca_pkg;

    typedef enum logic [2:0] {
        CCA_OFF,
        CCA_CAPTURE,
        CCA_SWTIMER,
        CCA_HSO,
        CCA_FREQ,
        CCA_PWM_SHORT,
        CCA_PWM16
    } cca_mode_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } cca_chan_st_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic run;
        logic cf;
        logic cf_en;
        logic [5:0] ccf;
        logic [7:0] cfg;
        logic [5:0][7:0] mode;
        logic [5:0][15:0] cmp;
        logic [5:0][15:0] rld;
        logic step;
        logic ovf16;
        logic cov;
        logic [7:0] rdata;
        logic irq;
        logic [5:0] oe;
    } cca_top_st_t;

    // Mode from one channel mode byte; unmatched patterns leave the channel idle
    function automatic cca_mode_t cca_decode(input logic [7:0] m);
        cca_mode_t r;
        r = CCA_OFF;
        if (m[`CCA_M_MATCH:`CCA_M_PWM] == 3'h0 && (m[`CCA_M_RISE] | m[`CCA_M_FALL])) begin
            r = CCA_CAPTURE;
        end else if (m[`CCA_M_RISE:`CCA_M_FALL] == 2'h0) begin
            if (!m[`CCA_M_MATCH] && m[`CCA_M_TOG] && m[`CCA_M_PWM]) begin
                r = CCA_FREQ;
            end else if (m[`CCA_M_PWM] && !m[`CCA_M_TOG]) begin
                r = m[`CCA_M_PWM16] ? CCA_PWM16 : CCA_PWM_SHORT;
            end else if (m[`CCA_M_MATCH] && m[`CCA_M_TOG] && !m[`CCA_M_PWM]) begin
                r = CCA_HSO;
            end else if (m[`CCA_M_MATCH] && !m[`CCA_M_TOG] && !m[`CCA_M_PWM]) begin
                r = CCA_SWTIMER;
            end
        end
        return r;
    endfunction

    // Low 8 to 11 counter bits that form one short PWM cycle
    function automatic logic [15:0] cca_cyc_mask(input logic [1:0] cls);
        logic [16:0] t;
        t = `CCA_CYC_BASE << cls;
        return t[15:0] - `CCA_ONE16;
    endfunction

endpackage

//--- hw/cca_top.sv
// Six-channel capture/compare array around one shared 16-bit counter.
// Assumes a processor register port on the same clock; channel pins are asynchronous.
//
// Overview of operation
// - Counter overflow flag sets whenever the shared 16-bit counter overflows.
// - That overflow is the wrap from all ones back to zero.
// - Cycle overflow flag sets on carry out of bit 7 to 10, per length select.
// - Each of six channels owns an event flag set by its mode's event.
// - All eight flags set on their event regardless of interrupt enables.
// - Interrupt rises when any flag and its own enable are both set.
// - Each channel picks one of six modes independently.
// - Mode bits 5 and 4 pick rising, falling or either capture edge.
// - Bits 3,2,1 select software timer, high-speed output or frequency output.
// - Bit 7 clear with PWM bit set gives 8 to 11 bit PWM.
// - Bit 7 and PWM bit set give 16-bit PWM.
// - All short PWM channels share one cycle length.
// - Mode bit 0 lets that channel's event flag request an interrupt.
// - Comparator disabled stops toggling and forces PWM output low.
// - View select routes compare byte accesses to compare or auto-reload.
// - With match flag enable, each PWM match sets the channel event flag.
// - Config bit 5 enables the cycle overflow interrupt.
// - A capture copies the full counter into the channel compare bytes.
// - Each capture sets that channel's event flag.
// - Flags stay set through service until software clears them.
// - Pin level stays readable to tell which edge captured.
`timescale 1ns/1ps
`include "cca_cfg.svh"

module cca_top (
    input wire logic i_ref_clk,           // System clock, 25 MHz
    input wire logic i_reset_n,           // Asynchronous reset, active low
    input wire logic [7:0] i_sfr_addr,    // Register index
    input wire logic i_sfr_wr,            // Write strobe
    input wire logic i_sfr_rd,            // Read strobe
    input wire logic [7:0] i_sfr_wdata,   // Write data
    output logic [7:0] o_sfr_rdata,       // Read data, one cycle after strobe
    output logic o_irq,                   // Array interrupt request
    input wire logic [5:0] i_channel_pin, // Channel pin levels in
    output logic [5:0] o_channel_pin,     // Channel pin levels out
    output logic [5:0] o_channel_pin_oe   // Channel pin drive enables
);
    localparam int LAG_MIN = 1;
    localparam int LAG_MAX = 2;

    logic [1:0] rst_q;
    logic rst_n;
    cca_pkg::cca_top_st_t st_reg, st_next;
    cca_chan_if ch_if[`CCA_NCH] ();
    logic [5:0] cap, evt, fstep, pin_lvl, pin_out;
    cca_pkg::cca_mode_t md;
    logic [15:0] cmask;
    logic [7:0] idx8;
    logic [2:0] idx;
    logic wr_ctrl, cov_now;
    logic [5:0] ch_en;

    // Reset release through two flops; assertion is immediate
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Channel slices share one counter and one cycle length
    genvar g;
    generate
        for (g = 0; g < `CCA_NCH; g++) begin : gch
            assign ch_if[g].mode = st_reg.mode[g];
            assign ch_if[g].cmp = st_reg.cmp[g];
            assign ch_if[g].cnt = st_reg.cnt;
            assign ch_if[g].cls = st_reg.cfg[`CCA_P_CLS_HI:0];
            assign ch_if[g].step = st_reg.step;
            assign ch_if[g].ovf16 = st_reg.ovf16;
            assign ch_if[g].cov = st_reg.cov;
            assign ch_if[g].pin_raw = i_channel_pin[g];
            assign cap[g] = ch_if[g].cap;
            assign evt[g] = ch_if[g].evt;
            assign fstep[g] = ch_if[g].fstep;
            assign pin_lvl[g] = ch_if[g].pin_lvl;
            assign pin_out[g] = ch_if[g].pin_out;
            cca_chan u_chan (
                .i_clk(i_ref_clk),
                .i_rst_n(rst_n),
                .ch(ch_if[g])
            );
        end
    endgenerate

    // Counter, flags, registers and read data
    always_comb begin
        st_next = st_reg;
        md = cca_pkg::CCA_OFF;
        idx8 = `CCA_ZERO8;
        idx = 3'h0;
        wr_ctrl = i_sfr_wr && (i_sfr_addr == `CCA_A_CTRL);
        // Counter runs on every clock while enabled
        cmask = cca_pkg::cca_cyc_mask(st_reg.cfg[`CCA_P_CLS_HI:0]);
        cov_now = st_reg.run && ((st_reg.cnt & cmask) == cmask);
        st_next.step = st_reg.run;
        st_next.ovf16 = st_reg.run && (st_reg.cnt == `CCA_ONES16);
        st_next.cov = cov_now;
        if (st_reg.run) begin
            st_next.cnt = st_reg.cnt + `CCA_ONE16;
        end
        // Counter step, then software writes; flag, capture and reload updates in the same cycle win
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                `CCA_A_CTRL: begin
                    st_next.run = i_sfr_wdata[`CCA_C_RUN];
                end
                `CCA_A_AMODE: st_next.cf_en = i_sfr_wdata[`CCA_AM_CFEN];
                `CCA_A_CNTL: st_next.cnt[7:0] = i_sfr_wdata;
                `CCA_A_CNTH: st_next.cnt[15:8] = i_sfr_wdata;
                `CCA_A_PWMCFG: st_next.cfg = i_sfr_wdata & `CCA_CFG_RMASK;
                default: begin
                    if (i_sfr_addr >= `CCA_A_MODE && i_sfr_addr < `CCA_A_MODE + `CCA_NCH8) begin
                        idx8 = i_sfr_addr - `CCA_A_MODE;
                        idx = idx8[2:0];
                        st_next.mode[idx] = i_sfr_wdata;
                    end else if (i_sfr_addr >= `CCA_A_CMPL
                                 && i_sfr_addr < `CCA_A_CMPL + `CCA_NCH8) begin
                        idx8 = i_sfr_addr - `CCA_A_CMPL;
                        idx = idx8[2:0];
                        if (st_reg.cfg[`CCA_P_VIEW]) begin
                            st_next.rld[idx][7:0] = i_sfr_wdata;
                        end else begin
                            st_next.cmp[idx][7:0] = i_sfr_wdata;
                            st_next.mode[idx][`CCA_M_CMPEN] = 1'b0;
                        end
                    end else if (i_sfr_addr >= `CCA_A_CMPH
                                 && i_sfr_addr < `CCA_A_CMPH + `CCA_NCH8) begin
                        idx8 = i_sfr_addr - `CCA_A_CMPH;
                        idx = idx8[2:0];
                        if (st_reg.cfg[`CCA_P_VIEW]) begin
                            st_next.rld[idx][15:8] = i_sfr_wdata;
                        end else begin
                            st_next.cmp[idx][15:8] = i_sfr_wdata;
                            st_next.mode[idx][`CCA_M_CMPEN] = 1'b1;
                        end
                    end
                end
            endcase
        end
        // Sticky flags: a write loads them, an event in the same cycle still sets
        st_next.cf = (wr_ctrl ? i_sfr_wdata[`CCA_C_CF] : st_reg.cf)
                     | st_next.ovf16;
        st_next.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG] = st_next.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG] | cov_now;
        st_next.ccf = (wr_ctrl ? i_sfr_wdata[5:0] : st_reg.ccf) | evt;
        // Per-channel data movement
        for (int i = 0; i < `CCA_NCH; i++) begin
            md = cca_pkg::cca_decode(st_reg.mode[i]);
            if (cap[i]) begin
                st_next.cmp[i] = st_reg.cnt;
            end
            if (fstep[i]) begin
                st_next.cmp[i][7:0] = st_reg.cmp[i][7:0] + st_reg.cmp[i][15:8];
            end
            // Short PWM reloads at cycle end; 8-bit length reloads from the high byte
            if (md == cca_pkg::CCA_PWM_SHORT && st_reg.cov) begin
                if (st_reg.cfg[`CCA_P_CLS_HI:0] == 2'h0) begin
                    st_next.cmp[i][7:0] = st_reg.cmp[i][15:8];
                end else begin
                    st_next.cmp[i] = st_reg.rld[i];
                end
            end
            st_next.oe[i] = (md != cca_pkg::CCA_OFF) && (md != cca_pkg::CCA_CAPTURE)
                            && (md != cca_pkg::CCA_SWTIMER);
            ch_en[i] = st_reg.mode[i][`CCA_M_IRQEN];
        end
        // Interrupt from enabled flags; global gating lives in the processor
        st_next.irq = (st_reg.cf & st_reg.cf_en)
                      | (st_reg.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG] & st_reg.cfg[`CCA_P_COVEN])
                      | (|(st_reg.ccf & ch_en));
        // Read data; unmapped indices read zero
        st_next.rdata = `CCA_ZERO8;
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                `CCA_A_CTRL: st_next.rdata = {st_reg.cf, st_reg.run, st_reg.ccf};
                `CCA_A_AMODE: st_next.rdata = {7'h00, st_reg.cf_en};
                `CCA_A_CNTL: st_next.rdata = st_reg.cnt[7:0];
                `CCA_A_CNTH: st_next.rdata = st_reg.cnt[15:8];
                `CCA_A_PWMCFG: st_next.rdata = st_reg.cfg;
                `CCA_A_PINLVL: st_next.rdata = {2'h0, pin_lvl};
                default: begin
                    if (i_sfr_addr >= `CCA_A_MODE && i_sfr_addr < `CCA_A_MODE + `CCA_NCH8) begin
                        idx8 = i_sfr_addr - `CCA_A_MODE;
                        st_next.rdata = st_reg.mode[idx8[2:0]];
                    end else if (i_sfr_addr >= `CCA_A_CMPL
                                 && i_sfr_addr < `CCA_A_CMPL + `CCA_NCH8) begin
                        idx8 = i_sfr_addr - `CCA_A_CMPL;
                        st_next.rdata = st_reg.cfg[`CCA_P_VIEW] ? st_reg.rld[idx8[2:0]][7:0]
                                        : st_reg.cmp[idx8[2:0]][7:0];
                    end else if (i_sfr_addr >= `CCA_A_CMPH
                                 && i_sfr_addr < `CCA_A_CMPH + `CCA_NCH8) begin
                        idx8 = i_sfr_addr - `CCA_A_CMPH;
                        st_next.rdata = st_reg.cfg[`CCA_P_VIEW] ? st_reg.rld[idx8[2:0]][15:8]
                                        : st_reg.cmp[idx8[2:0]][15:8];
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sfr_rdata = st_reg.rdata;
    assign o_irq = st_reg.irq;
    assign o_channel_pin = pin_out;
    assign o_channel_pin_oe = st_reg.oe;

    // Checks on channels 0 and 3 and the shared flags
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    a_wrap_sets_cf: assert property (
        st_reg.run && st_reg.cnt == `CCA_ONES16 |-> ##LAG_MIN st_reg.cf && st_reg.cnt == 16'h0000)
        else $error("Counter wrap did not set overflow flag");
    a_cycle_sets_cycle_overflow_flag: assert property (
        st_reg.run && ((st_reg.cnt & cmask) == cmask) |=> st_reg.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG])
        else $error("Cycle overflow flag missed");
    a_flag_stays_set: assert property (
        st_reg.ccf[0] && !(i_sfr_wr && i_sfr_addr == `CCA_A_CTRL) |=> st_reg.ccf[0])
        else $error("Channel flag cleared without software");
    a_irq_on_enabled: assert property (
        st_reg.cf && st_reg.cf_en |=> o_irq)
        else $error("Enabled flag raised no interrupt");
    a_capture_loads: assert property (
        cap[0] |=> st_reg.cmp[0] == $past(st_reg.cnt))
        else $error("Capture did not load counter");
    a_capture_flags: assert property (
        cap[0] |=> st_reg.ccf[0])
        else $error("Capture did not set event flag");
    a_view_routes: assert property (
        i_sfr_wr && i_sfr_addr == `CCA_A_CMPL && st_reg.cfg[`CCA_P_VIEW] && !cap[0]
        |=> st_reg.rld[0][7:0] == $past(i_sfr_wdata) && $stable(st_reg.cmp[0]))
        else $error("Compare view routing wrong");
    // Channel 3 is the one set up as a disabled 16-bit PWM
    a_pwm_off_low: assert property (
        (st_reg.mode[3][`CCA_M_PWM] && !st_reg.mode[3][`CCA_M_TOG]
         && st_reg.mode[3][`CCA_M_RISE:`CCA_M_FALL] == 2'h0
         && !st_reg.mode[3][`CCA_M_CMPEN])[*3] |-> ##[LAG_MIN:LAG_MAX] !o_channel_pin[3])
        else $error("Disabled PWM output not low");

    // Counter steps by one while running and holds while stopped
    a_count_steps: assert property (
        st_reg.run && !i_sfr_wr |=> st_reg.cnt == $past(st_reg.cnt) + `CCA_ONE16)
        else $error("Counter did not step by one");
    a_count_holds: assert property (
        !st_reg.run && !i_sfr_wr |=> $stable(st_reg.cnt))
        else $error("Stopped counter moved");
    a_cf_from_wrap: assert property (
        $rose(st_reg.cf) |-> st_reg.ovf16 || $past(wr_ctrl))
        else $error("Overflow flag set without a wrap");

    // Flags fall only by a software write; events always set them
    a_cf_sticky: assert property (
        st_reg.cf && !wr_ctrl |=> st_reg.cf)
        else $error("Overflow flag cleared without software");
    a_cycle_overflow_flag_sticky: assert property (
        st_reg.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG] && !(i_sfr_wr && i_sfr_addr == `CCA_A_PWMCFG)
        |=> st_reg.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG])
        else $error("Cycle flag cleared without software");
    a_event_flags: assert property (
        |evt |=> (st_reg.ccf & $past(evt)) == $past(evt))
        else $error("Channel event did not set its flag");

    // Interrupt follows flag and enable one cycle late
    a_irq_channel: assert property (
        st_reg.ccf[0] && st_reg.mode[0][`CCA_M_IRQEN] |=> o_irq)
        else $error("Enabled channel flag raised no interrupt");
    a_irq_cycle: assert property (
        st_reg.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG] && st_reg.cfg[`CCA_P_COVEN] |=> o_irq)
        else $error("Enabled cycle flag raised no interrupt");
    a_irq_quiet: assert property (
        !(st_reg.cf && st_reg.cf_en) && !(st_reg.cfg[`CCA_P_CYCLE_OVERFLOW_FLAG] && st_reg.cfg[`CCA_P_COVEN])
        && !(|(st_reg.ccf & ch_en)) |=> !o_irq)
        else $error("Interrupt without an enabled flag");

    // Register port answers from the state of the strobe cycle
    a_mode_write: assert property (
        i_sfr_wr && i_sfr_addr == `CCA_A_MODE |=> st_reg.mode[0] == $past(i_sfr_wdata))
        else $error("Mode write did not land");
    a_pin_read: assert property (
        i_sfr_rd && i_sfr_addr == `CCA_A_PINLVL |=> o_sfr_rdata[5:0] == $past(pin_lvl))
        else $error("Pin level read wrong");
    a_view_read: assert property (
        i_sfr_rd && i_sfr_addr == `CCA_A_CMPL && st_reg.cfg[`CCA_P_VIEW]
        |=> o_sfr_rdata == $past(st_reg.rld[0][7:0]))
        else $error("Reload view read wrong");
    // A capture pin is never driven, so its level stays meaningful
    a_capture_no_drive: assert property (
        cca_pkg::cca_decode(st_reg.mode[0]) == cca_pkg::CCA_CAPTURE |=> !o_channel_pin_oe[0])
        else $error("Capture pin driven");

    c_capture: cover property (cap[0]);
    c_match: cover property (evt[4]);
    c_wrap: cover property (st_reg.ovf16);
    c_pwm_high: cover property (st_reg.oe[0] && o_channel_pin[0]);
    c_irq: cover property ($rose(o_irq));
endmodule

//--- verif/cca_pin_model.sv
// Outside source for the six channel pins: steps each pin to the level asked for.
// Assumes the bench clock is the array's system clock; the pins carry no pull.
`timescale 1ns/1ps

module cca_pin_model (
    input wire logic i_clk,        // System clock
    input wire logic [5:0] i_want, // Levels asked for by the bench
    output logic [5:0] o_pin       // Levels on the pins
);
    logic [1:0] held_reg;

    initial begin
        o_pin = 6'h00;
        held_reg = 2'h0;
    end

    // Each level stands two clocks at least, or the synchroniser could miss it
    always @(posedge i_clk) begin
        if (i_want != o_pin && held_reg != 2'h0) begin
            o_pin <= #7 i_want;
            held_reg <= 2'h0;
        end else if (held_reg != 2'h3) begin
            held_reg <= held_reg + 2'h1;
        end
    end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the capture/compare array: registers, captures, flags, interrupt.
// Assumes cca_top and cca_pin_model are compiled first; counter runs at the system clock.
`timescale 1ns/1ps

module testbench;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cca_row_t;
    logic clk, rst_n, wr, rd, irq;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] want, pin_in, pin_out, pin_oe, ext;
    int errors, n_tests;
    logic [7:0] rst_a [6] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h18};
    // Write value, expected read back; modes differ per channel on purpose
    cca_row_t rows [9] = '{'{8'h08, 8'h21, 8'h21}, '{8'h09, 8'h10, 8'h10},
        '{8'h0A, 8'h30, 8'h30}, '{8'h0B, 8'h82, 8'h82}, '{8'h0C, 8'h04, 8'h04},
        '{8'h0D, 8'h46, 8'h46}, '{8'h06, 8'hFF, 8'h00}, '{8'h04, 8'hA3, 8'hA3},
        '{8'h04, 8'h00, 8'h00}};

    cca_top dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_irq(irq),
        .i_channel_pin(pin_in), .o_channel_pin(pin_out), .o_channel_pin_oe(pin_oe));
    cca_pin_model pins (.i_clk(clk), .i_want(want), .o_pin(ext));

    // Wire level: the array drives where it enables, the outside source elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Strobes rise and fall on falling edges, one idle cycle between accesses
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk8(rdata & m, e);
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Counter bytes go separately; only safe while the counter is stopped
    task automatic cnt(input logic [15:0] c);
        wr_reg(8'h02, c[7:0]);
        wr_reg(8'h03, c[15:8]);
    endtask

    task automatic final_report();
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run is about 370 cycles; this cuts a hang well beyond that
    initial begin
        #800000;
        errors++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        want = 6'h00;
        errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rst_a[i]) rdc(rst_a[i], 8'hFF, 8'h00);
        chk1(irq, 1'b0);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rdc(rows[i].a, 8'hFF, rows[i].e);
        end
        // Rising edges on pins 0 to 2: rising and either-edge channels capture
        cnt(16'h1234);
        want = 6'h07;
        repeat (8) @(negedge clk);
        rdc(8'h00, 8'hFF, 8'h05);
        chk1(irq, 1'b1);
        rdc(8'h10, 8'hFF, 8'h34);
        rdc(8'h18, 8'hFF, 8'h12);
        rdc(8'h11, 8'hFF, 8'h00);
        rdc(8'h05, 8'h07, 8'h07);
        // Falling edges: falling and either-edge channels take the new count
        cnt(16'hABCD);
        want = 6'h00;
        repeat (8) @(negedge clk);
        rdc(8'h00, 8'hFF, 8'h07);
        rdc(8'h19, 8'hFF, 8'hAB);
        rdc(8'h12, 8'hFF, 8'hCD);
        rdc(8'h05, 8'h07, 8'h00);
        repeat (20) @(negedge clk);
        rdc(8'h00, 8'hFF, 8'h07);
        wr_reg(8'h00, 8'h00);
        rdc(8'h00, 8'hFF, 8'h00);
        chk1(irq, 1'b0);
        // View select moves compare bytes onto the reload copy
        wr_reg(8'h04, 8'h80);
        wr_reg(8'h10, 8'h55);
        rdc(8'h10, 8'hFF, 8'h55);
        wr_reg(8'h04, 8'h00);
        rdc(8'h10, 8'hFF, 8'h34);
        // Wrap near all ones; flag rises with its interrupt still disabled
        cnt(16'hFFF0);
        wr_reg(8'h00, 8'h40);
        rdc(8'h00, 8'h80, 8'h00);
        repeat (16) @(negedge clk);
        rdc(8'h00, 8'h80, 8'h80);
        chk1(irq, 1'b0);
        chk1(pin_out[3], 1'b0);
        chk1(pin_oe[3], 1'b1);
        wr_reg(8'h01, 8'h01);
        repeat (2) @(negedge clk);
        chk1(irq, 1'b1);
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h00, 8'h00);
        // Each cycle length: no flag short of the carry bit, flag once past it
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h04, 8'h20 | 8'(k));
            cnt((16'h0100 << k) - 16'h0014);
            wr_reg(8'h00, 8'h40);
            rdc(8'h04, 8'h40, 8'h00);
            chk1(irq, 1'b0);
            repeat (20) @(negedge clk);
            rdc(8'h04, 8'h40, 8'h40);
            chk1(irq, 1'b1);
            wr_reg(8'h00, 8'h00);
            wr_reg(8'h04, 8'h00);
        end
        // Full PWM with match flag enabled: compare hit sets the channel flag
        cnt(16'h0000);
        wr_reg(8'h14, 8'h10);
        wr_reg(8'h1C, 8'h00);
        wr_reg(8'h0C, 8'hCA);
        wr_reg(8'h00, 8'h40);
        repeat (30) @(negedge clk);
        rdc(8'h00, 8'h10, 8'h10);
        final_report();
    end
endmodule
